// [ser_pkg.sv]
// constants shared by the system error reporter files
package ser_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // error causes, one pending bit each, lowest index reported first
  localparam int unsigned NUM_CAUSE      = 5;
  localparam int unsigned CAUSE_PARAM    = 0;
  localparam int unsigned CAUSE_MISMATCH = 1;
  localparam int unsigned CAUSE_TASK1    = 2;
  localparam int unsigned CAUSE_TASK2    = 3;
  localparam int unsigned CAUSE_DECEL    = 4;
  localparam int unsigned NUM_TASK       = 2;

  // four-digit bcd codes
  localparam logic [15:0] CODE_NONE      = 16'h0000;
  localparam logic [15:0] CODE_SYS_MIN   = 16'h0001;
  localparam logic [15:0] CODE_SYS_MAX   = 16'h0017;
  localparam logic [15:0] CODE_PARAM     = 16'h0001;
  localparam logic [15:0] CODE_MISMATCH  = 16'h0002;
  localparam logic [15:0] CODE_TASK1     = 16'h0003;
  localparam logic [15:0] CODE_TASK2     = 16'h0004;
  localparam logic [15:0] CODE_DECEL     = 16'h0010;

  localparam logic [NUM_CAUSE-1:0][15:0] CAUSE_CODE =
    {CODE_DECEL, CODE_TASK2, CODE_TASK1, CODE_MISMATCH, CODE_PARAM};

  // causes that an ordinary error reset may clear
  localparam logic [NUM_CAUSE-1:0] RESETTABLE = 5'h10;

  //////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam int unsigned ADDR_W        = 5;
  localparam logic [4:0]  OFS_STATUS    = 5'h00;
  localparam logic [4:0]  OFS_CODE      = 5'h04;
  localparam logic [4:0]  OFS_FIRST     = 5'h08;
  localparam logic [4:0]  OFS_CTRL      = 5'h0C;
  localparam logic [4:0]  OFS_CAUSE     = 5'h10;
  localparam logic [4:0]  OFS_IRQ_STAT  = 5'h14;
  localparam logic [4:0]  OFS_IRQ_MASK  = 5'h18;

  localparam int unsigned STATUS_ERR_BIT = 14;
  localparam int unsigned CTRL_RESET_BIT = 0;

  // interrupt status layout
  localparam int unsigned IRQ_W         = 3;
  localparam int unsigned IRQ_RAISE     = 0;
  localparam int unsigned IRQ_DROP      = 1;
  localparam int unsigned IRQ_CODE      = 2;
  localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;
  localparam logic [2:0]  IRQ_STAT_RST  = 3'h0;

endpackage

// [ser_err_if.sv]
// carrier between the pending flags and the code selector
`timescale 1ns/1ns
interface ser_err_if;
  logic [ser_pkg::NUM_CAUSE-1:0] pend;
  logic [15:0]                   code;
  logic                          any;

  modport sel
  (
    input  pend,
    output code,
    output any
  );

  modport ctrl
  (
    output pend,
    input  code,
    input  any
  );
endinterface

// [ser_code_sel.sv]
// picks the code of the highest priority pending error
`timescale 1ns/1ns
module ser_code_sel
(
  ser_err_if.sel err
);

  always_comb
  begin
    err.code = ser_pkg::CODE_NONE;
    err.any  = |err.pend;
    // walk down so the lowest pending index wins
    for (int i = ser_pkg::NUM_CAUSE - 1; i >= 0; i--)
    begin
      if (err.pend[i])
      begin
        err.code = ser_pkg::CAUSE_CODE[i];
      end
    end
  end

endmodule

// [ser_reporter.sv]
// system error reporter: pending flags, host words, avalon-mm slave, interrupt
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns

// Behaviour
// - System error codes lie between 0001 and 0017, apart from task and axis codes.
// - On a system error the four-digit bcd code is written to the expansion code word.
// - On a system error bit 14 of the interface status word is set.
// - Corrupt stored parameters give code 0001, which only a power cycle clears.
// - A task count that differs from the stored programs gives code 0002.
// - Code 0002 ignores error reset and clears once all stored programs are deleted.
// - A corrupt task 1 program gives code 0003.
// - The first error code that occurs is also kept in the work-area word.
// - A corrupt task 2 program gives code 0004, cleared like the task 1 case.
// - A deceleration stop request gives code 0010, cleared by reset, raised again if held.
module ser_reporter
#(
  parameter int unsigned TASK_CNT_W = 2
)
(
  input  wire logic                            clock,
  input  wire logic                            rst_n,
  input  wire logic [ser_pkg::ADDR_W-1:0]      avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [31:0]                     avs_writedata,
  input  wire logic [3:0]                      avs_byteenable,
  output logic      [31:0]                     avs_readdata,
  output logic                                 avs_waitrequest,
  input  wire logic                            param_corrupt,
  input  wire logic [TASK_CNT_W-1:0]           cfg_task_count,
  input  wire logic [TASK_CNT_W-1:0]           prog_task_count,
  input  wire logic                            prog_store_empty,
  input  wire logic [ser_pkg::NUM_TASK-1:0]    task_prog_bad,
  input  wire logic [ser_pkg::NUM_TASK-1:0]    task_prog_empty,
  input  wire logic                            decel_stop_req,
  output logic      [15:0]                     status_word,
  output logic      [15:0]                     code_word,
  output logic      [15:0]                     first_code_word,
  output logic                                 irq
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  ser_err_if err ();

  logic                          wait_q;
  logic [31:0]                   rdata_q;
  logic [31:0]                   rdata_d;
  logic                          req;
  logic                          accept;
  logic                          wr_acc;
  logic                          rd_acc;
  logic                          err_reset;

  logic                          param_bad_q;
  logic                          mismatch_q;
  logic [ser_pkg::NUM_TASK-1:0]  task_bad_q;
  logic                          decel_q;

  logic [15:0]                   status_q;
  logic [15:0]                   code_q;
  logic [15:0]                   first_q;
  logic                          first_seen_q;

  logic [ser_pkg::IRQ_W-1:0]     irq_stat_q;
  logic [ser_pkg::IRQ_W-1:0]     irq_stat_d;
  logic [ser_pkg::IRQ_W-1:0]     irq_mask_q;
  logic [ser_pkg::IRQ_W-1:0]     irq_event;
  logic [ser_pkg::IRQ_W-1:0]     irq_clear;
  logic                          irq_q;

  //////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait cycle on every access

  assign req    = avs_read | avs_write;
  assign accept = req & ~wait_q;
  assign wr_acc = accept & avs_write;
  assign rd_acc = accept & avs_read;

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wait_q <= 1'b1;
    end
    else
    begin
      // low for exactly one cycle per request, then back high
      wait_q <= ~(req & wait_q);
    end
  end

  always_comb
  begin
    rdata_d = 32'h00000000;
    case (avs_address)
      ser_pkg::OFS_STATUS:   rdata_d[15:0] = status_q;
      ser_pkg::OFS_CODE:     rdata_d[15:0] = code_q;
      ser_pkg::OFS_FIRST:    rdata_d[15:0] = first_q;
      ser_pkg::OFS_CTRL:     rdata_d = 32'h00000000;
      ser_pkg::OFS_CAUSE:    rdata_d[ser_pkg::NUM_CAUSE-1:0] = err.pend;
      ser_pkg::OFS_IRQ_STAT: rdata_d[ser_pkg::IRQ_W-1:0] = irq_stat_q;
      ser_pkg::OFS_IRQ_MASK: rdata_d[ser_pkg::IRQ_W-1:0] = irq_mask_q;
      default:               rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (avs_read && wait_q)
    begin
      // sampled as the wait cycle ends, so it stands through the accept edge
      rdata_q <= rdata_d;
    end
  end

  // error reset command: a one written to the control bit
  assign err_reset = wr_acc && (avs_address == ser_pkg::OFS_CTRL) && avs_byteenable[0]
                     && avs_writedata[ser_pkg::CTRL_RESET_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // pending error flags

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      param_bad_q <= 1'b0;
    end
    else if (param_corrupt)
    begin
      // no clear path: only a fresh power-up drops it
      param_bad_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      mismatch_q <= 1'b0;
    end
    else if (prog_store_empty)
    begin
      mismatch_q <= 1'b0;
    end
    else if (cfg_task_count != prog_task_count)
    begin
      mismatch_q <= 1'b1;
    end
  end

  for (genvar t = 0; t < ser_pkg::NUM_TASK; t++)
  begin : g_task
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
      if (!rst_sync_n)
      begin
        task_bad_q[t] <= 1'b0;
      end
      else if (task_prog_bad[t])
      begin
        // a fresh fault outranks a deletion seen in the same cycle
        task_bad_q[t] <= 1'b1;
      end
      else if (task_prog_empty[t])
      begin
        task_bad_q[t] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      decel_q <= 1'b0;
    end
    else if (decel_stop_req)
    begin
      // a held request wins over the reset, so the error returns
      decel_q <= 1'b1;
    end
    else if (err_reset)
    begin
      decel_q <= 1'b0;
    end
  end

  assign err.pend = {decel_q, task_bad_q, mismatch_q, param_bad_q};

  ser_code_sel u_sel
  (
    .err (err)
  );

  //////////////////////////////////////////////////////////////////////////////
  // host-visible words

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      status_q <= 16'h0000;
      code_q   <= ser_pkg::CODE_NONE;
    end
    else
    begin
      // flag and code fall only once no pending cause is left
      status_q                         <= 16'h0000;
      status_q[ser_pkg::STATUS_ERR_BIT] <= err.any;
      code_q                           <= err.code;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      first_q      <= ser_pkg::CODE_NONE;
      first_seen_q <= 1'b0;
    end
    else if (err.any && !first_seen_q)
    begin
      // kept until power-up, error reset does not touch it
      first_q      <= err.code;
      first_seen_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt: sticky events, cleared by reading them

  always_comb
  begin
    irq_event                    = '0;
    irq_event[ser_pkg::IRQ_RAISE] = err.any & ~status_q[ser_pkg::STATUS_ERR_BIT];
    irq_event[ser_pkg::IRQ_DROP]  = ~err.any & status_q[ser_pkg::STATUS_ERR_BIT];
    irq_event[ser_pkg::IRQ_CODE]  = err.code != code_q;
  end

  // clear only what the read returned; later events survive
  assign irq_clear  = (rd_acc && avs_address == ser_pkg::OFS_IRQ_STAT)
                      ? rdata_q[ser_pkg::IRQ_W-1:0] : '0;
  assign irq_stat_d = (irq_stat_q & ~irq_clear) | irq_event;

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      irq_stat_q <= ser_pkg::IRQ_STAT_RST;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      irq_mask_q <= ser_pkg::IRQ_MASK_RST;
    end
    else if (wr_acc && avs_address == ser_pkg::OFS_IRQ_MASK && avs_byteenable[0])
    begin
      irq_mask_q <= avs_writedata[ser_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign status_word     = status_q;
  assign code_word       = code_q;
  assign first_code_word = first_q;
  assign irq             = irq_q;

endmodule

// [ser_reporter_properties.sv]
// concurrent checks on the reporter top ports
`timescale 1ns/1ns
module ser_reporter_properties
#(
  parameter int unsigned TASK_CNT_W = 2
)
(
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic                  avs_waitrequest,
  input wire logic                  param_corrupt,
  input wire logic [TASK_CNT_W-1:0] cfg_task_count,
  input wire logic [TASK_CNT_W-1:0] prog_task_count,
  input wire logic                  prog_store_empty,
  input wire logic [1:0]            task_prog_bad,
  input wire logic                  decel_stop_req,
  input wire logic [15:0]           status_word,
  input wire logic [15:0]           code_word,
  input wire logic [15:0]           first_code_word
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  wire logic calm;
  // no parameter or task fault arriving, and no task-count mismatch being latched
  assign calm = !param_corrupt && task_prog_bad == 2'b00
                && (prog_store_empty || cfg_task_count == prog_task_count);
  // two calm cycles: no sticky cause can still be on its way
  sequence s_calm;
    calm [*2];
  endsequence
  sequence s_no_param;
    !param_corrupt && !$past(param_corrupt) && code_word != 16'h0001;
  endsequence
  a_code_range: assert property (code_word != 16'h0000 |-> code_word <= 16'h0017)
    else $error("code outside system range");
  a_flag_code: assert property ((code_word != 16'h0000) == (status_word == 16'h4000))
    else $error("flag and code disagree");
  a_param_sticky: assert property (code_word == 16'h0001 |=> code_word == 16'h0001)
    else $error("parameter error cleared");
  a_first_hold: assert property (first_code_word != 16'h0000 |=> $stable(first_code_word))
    else $error("first code changed");
  a_mismatch_code: assert property (s_no_param ##0 cfg_task_count != prog_task_count
    && !prog_store_empty |-> ##2 code_word == 16'h0002) else $error("no mismatch code");
  a_task1_code: assert property (s_no_param ##0 task_prog_bad[0] && prog_store_empty
    |-> ##2 code_word == 16'h0003) else $error("no task 1 code");
  a_decel_code: assert property (s_calm ##0 decel_stop_req && status_word == 16'h0000
    |-> ##2 code_word == 16'h0010) else $error("no decel code");
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule

// [ser_host.sv]
// host controller model: avalon-mm master reading the reporter words
`timescale 1ns/1ns
module ser_host
(
  input  wire logic        clock,
  output logic      [4:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial
  begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
  end
  // one edge before raising, so a release never meets a new request
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    int i;
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clock);
      if (!avs_waitrequest)
        break;
    end
    rd = avs_readdata;
    ok = i < 50;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule

// [system_error_reporter_tb_top.sv]
// self-checking testbench of the system error reporter
`timescale 1ns/1ns
module system_error_reporter_tb_top;
  logic        clock;
  logic        rst_n;
  logic [4:0]  adr;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] wdat;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        wait_rq;
  logic        param_corrupt;
  logic [1:0]  cfg_cnt;
  logic [1:0]  prog_cnt;
  logic        store_empty;
  logic [1:0]  bad;
  logic [1:0]  empty;
  logic        decel;
  logic [15:0] status_word;
  logic [15:0] code_word;
  logic [15:0] first_code_word;
  logic        irq;
  int          fails;
  int          checks_done;
  ser_reporter DUT (.clock(clock), .rst_n(rst_n), .avs_address(adr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_rq), .param_corrupt(param_corrupt), .cfg_task_count(cfg_cnt),
    .prog_task_count(prog_cnt), .prog_store_empty(store_empty), .task_prog_bad(bad),
    .task_prog_empty(empty), .decel_stop_req(decel), .status_word(status_word),
    .code_word(code_word), .first_code_word(first_code_word), .irq(irq));
  ser_host host (.clock(clock), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_rq));
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
                     input logic [15:0] exp);
    logic [31:0] r;
    logic        ok;
    host.xfer(wr, a, {16'h0000, d}, r, ok);
    if (!ok)
    begin
      fails++;
      wrap_up();
    end
    if (!wr)
      chk(r[15:0], exp);
  endtask
  task automatic words(input logic [15:0] c);
    w(4);
    chk(code_word, c);
    chk(status_word, (c != 16'h0000) ? 16'h4000 : 16'h0000);
  endtask
  task automatic err_reset;
    bus(1'b1, ser_pkg::OFS_CTRL, 16'h0001, 16'h0000);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic s_decel;
    decel <= 1'b1;
    w(1);
    decel <= 1'b0;
    words(16'h0010);
    chk(first_code_word, 16'h0010);
    bus(1'b0, ser_pkg::OFS_IRQ_STAT, 16'h0000, 16'h0005);
    bus(1'b1, ser_pkg::OFS_IRQ_MASK, 16'h0002, 16'h0000);
    bus(1'b0, ser_pkg::OFS_IRQ_MASK, 16'h0000, 16'h0002);
    chk({15'h0000, irq}, 16'h0000);
    err_reset();
    words(16'h0000);
    chk({15'h0000, irq}, 16'h0001);
    bus(1'b0, ser_pkg::OFS_IRQ_STAT, 16'h0000, 16'h0006);
    w(3);
    chk({15'h0000, irq}, 16'h0000);
    bus(1'b0, 5'h1C, 16'h0000, 16'h0000);
    decel <= 1'b1;
    w(3);
    err_reset();
    words(16'h0010);
    decel <= 1'b0;
    err_reset();
    words(16'h0000);
  endtask
  task automatic s_task;
    // empty store keeps a task-count mismatch out of the way
    store_empty <= 1'b1;
    bad <= 2'b10;
    words(16'h0004);
    bad <= 2'b11;
    words(16'h0003);
    bad <= 2'b00;
    err_reset();
    words(16'h0003);
    empty <= 2'b01;
    words(16'h0004);
    empty <= 2'b11;
    words(16'h0000);
    empty <= 2'b00;
    store_empty <= 1'b0;
  endtask
  task automatic s_mismatch;
    cfg_cnt <= 2'h2;
    words(16'h0002);
    err_reset();
    words(16'h0002);
    store_empty <= 1'b1;
    words(16'h0000);
    cfg_cnt <= 2'h1;
    store_empty <= 1'b0;
  endtask
  task automatic s_param;
    param_corrupt <= 1'b1;
    w(1);
    param_corrupt <= 1'b0;
    words(16'h0001);
    err_reset();
    bus(1'b1, ser_pkg::OFS_CODE, 16'h1234, 16'h0000);
    words(16'h0001);
    bus(1'b0, ser_pkg::OFS_CODE, 16'h0000, 16'h0001);
    bus(1'b0, ser_pkg::OFS_CAUSE, 16'h0000, 16'h0001);
    chk(first_code_word, 16'h0010);
    rst_n <= 1'b0;
    w(3);
    rst_n <= 1'b1;
    words(16'h0000);
    chk(first_code_word, 16'h0000);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    fails = 0;
    checks_done = 0;
    rst_n = 1'b0;
    param_corrupt = 1'b0;
    cfg_cnt = 2'h1;
    prog_cnt = 2'h1;
    store_empty = 1'b0;
    bad = 2'b00;
    empty = 2'b00;
    decel = 1'b0;
    w(12);
    rst_n <= 1'b1;
    w(5);
    s_decel();
    s_task();
    s_mismatch();
    s_param();
    wrap_up();
  end
endmodule
bind ser_reporter ser_reporter_properties #(.TASK_CNT_W(TASK_CNT_W)) u_props
(
  .clock            (clock),
  .rst_n            (rst_n),
  .avs_read         (avs_read),
  .avs_write        (avs_write),
  .avs_waitrequest  (avs_waitrequest),
  .param_corrupt    (param_corrupt),
  .cfg_task_count   (cfg_task_count),
  .prog_task_count  (prog_task_count),
  .prog_store_empty (prog_store_empty),
  .task_prog_bad    (task_prog_bad),
  .decel_stop_req   (decel_stop_req),
  .status_word      (status_word),
  .code_word        (code_word),
  .first_code_word  (first_code_word)
);
